// ### common/pmt_consts.svh
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define PMT_OFF_CONTROL     8'h00
`define PMT_OFF_COUNT       8'h04
`define PMT_OFF_PERIOD      8'h08
`define PMT_OFF_STATUS      8'h0c
`define PMT_OFF_MASK        8'h10
`define PMT_OFF_SLEEP       8'h14

// ==========================================================
// Field positions and reset values
`define PMT_RUN_BIT         2
`define PMT_PRE_LSB         0
`define PMT_POST_LSB        3
`define PMT_CONTROL_RST     8'h00
`define PMT_COUNT_RST       8'h00
`define PMT_PERIOD_RST      8'hff
`define PMT_CONTROL_WMASK   8'h7f

// ==========================================================
// Timing
`define PMT_INSTR_DIV       4

// ==========================================================
// Bus responses
`define PMT_RESP_OKAY       2'b00
`define PMT_RESP_SLVERR     2'b10

`endif

// ### common/pmt_pkg.sv
package pmt_pkg;
  typedef enum logic [1:0] {
    PMT_PRE_1,
    PMT_PRE_4,
    PMT_PRE_16,
    PMT_PRE_64
  } pmt_prescale_t;

  typedef logic [7:0] pmt_byte_t;
endpackage

// ### hw/pmt_prescaler.sv
`include "pmt_consts.svh"

// Instruction clock divider followed by the selectable prescaler
module pmt_prescaler (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clear,
  input  wire logic                  run,
  input  wire pmt_pkg::pmt_prescale_t select,
  output logic                       tick
);
  import pmt_pkg::*;

  logic [1:0] instr_div;
  logic [5:0] pre_count;
  logic       instr_tick;
  logic [5:0] pre_last;

  // ==========================================================
  // Instruction clock: one tick every fourth aclk
  assign instr_tick = (instr_div == 2'(`PMT_INSTR_DIV - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // ==========================================================
  // Prescale ratio
  assign pre_last = (select == PMT_PRE_1)  ? 6'h00 :
                    (select == PMT_PRE_4)  ? 6'h03 :
                    (select == PMT_PRE_16) ? 6'h0f : 6'h3f;

  assign tick = run && instr_tick && (pre_count >= pre_last);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      pre_count <= 6'h00;
    end else if (run && instr_tick) begin
      pre_count <= (pre_count >= pre_last) ? 6'h00 : pre_count + 6'h01;
    end
  end
endmodule

// ### hw/pmt_postscaler.sv
`include "pmt_consts.svh"

// Counts match pulses, pulses done at the selected terminal count
module pmt_postscaler #(
  parameter int WIDTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clear,
  input  wire logic             match,
  input  wire logic [WIDTH-1:0] select,
  output logic                  done
);
  logic [WIDTH-1:0] post_count;

  assign done = match && (post_count >= select);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      post_count <= '0;
    end else if (match) begin
      post_count <= done ? '0 : post_count + WIDTH'(1);
    end
  end
endmodule

// ### hw/pmt_timer.sv
// The AXI4-Lite register port and the register offsets were left to the implementer.
`include "pmt_consts.svh"

// What this block does
// - Timer clocked only from instruction clock
// - Count and period are 8-bit, read/write
// - Count increments from zero per prescaled tick
// - Prescale field selects 1, 4, 16, 64
// - Compare count with period every cycle
// - Match reloads count with zero on next prescaled tick
// - Reset clears count, sets period all ones
// - Count or control write clears both scalers
// - Control write leaves count unchanged
// - Matches drive postscaler setting match flag
// - Postscale ratio is field value plus one
// - Interrupt only when flag and enable set
// - Run bit 2 starts and stops counting
// - Bit 7 reads zero; postscale 6:3, prescale 1:0
// - Unscaled match is the PWM time base
// - Match also offered as SPI shift clock
// - Sleep halts counting, registers kept
module pmt_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cpu_sleep,
  output logic             pwm_time_base,
  output logic             spi_shift_clock,
  output logic             irq
);
  import pmt_pkg::*;

  // ==========================================================
  // State
  pmt_byte_t  timer_control;
  pmt_byte_t  timer_count;
  pmt_byte_t  timer_period;
  logic       match_flag;
  logic       match_irq_enable;
  logic       sleep_reg;
  logic       aw_held;
  logic [7:0] aw_addr;
  logic       w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ==========================================================
  // Control fields
  logic          timer_run_bit;
  logic [3:0]    postscale_select;
  pmt_prescale_t prescale_select;
  logic          asleep;
  logic          running;

  assign timer_run_bit    = timer_control[`PMT_RUN_BIT];
  assign postscale_select = timer_control[`PMT_POST_LSB +: 4];
  assign prescale_select  = pmt_prescale_t'(timer_control[`PMT_PRE_LSB +: 2]);
  assign asleep           = cpu_sleep || sleep_reg;
  assign running          = timer_run_bit && !asleep;

  // ==========================================================
  // Write channel decode
  logic        do_write;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_lane0;
  logic        wr_control;
  logic        wr_count;
  logic        wr_period;
  logic        wr_mask;
  logic        wr_sleep;
  logic        wr_mapped;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction

  assign wr_addr    = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data    = w_held ? w_data : s_axi_wdata;
  assign wr_strb    = w_held ? w_strb : s_axi_wstrb;
  assign do_write   = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  assign wr_lane0   = do_write && wr_strb[0];
  assign wr_control = wr_lane0 && addr_hit(wr_addr, `PMT_OFF_CONTROL);
  assign wr_count   = wr_lane0 && addr_hit(wr_addr, `PMT_OFF_COUNT);
  assign wr_period  = wr_lane0 && addr_hit(wr_addr, `PMT_OFF_PERIOD);
  assign wr_mask    = wr_lane0 && addr_hit(wr_addr, `PMT_OFF_MASK);
  assign wr_sleep   = wr_lane0 && addr_hit(wr_addr, `PMT_OFF_SLEEP);
  assign wr_mapped  = addr_hit(wr_addr, `PMT_OFF_CONTROL) || addr_hit(wr_addr, `PMT_OFF_COUNT) ||
                      addr_hit(wr_addr, `PMT_OFF_PERIOD) || addr_hit(wr_addr, `PMT_OFF_STATUS) ||
                      addr_hit(wr_addr, `PMT_OFF_MASK) || addr_hit(wr_addr, `PMT_OFF_SLEEP);

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // Address and data may arrive in either order; hold the early one
  always_ff @(posedge aclk) begin
    if (!aresetn || do_write) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || do_write) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PMT_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Timer core
  logic tick;
  logic match;
  logic scaler_clear;
  logic post_done;

  assign scaler_clear = wr_count || wr_control;
  assign match        = (timer_count == timer_period);
  assign pwm_time_base   = match;
  assign spi_shift_clock = match;

  pmt_prescaler u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (scaler_clear),
    .run     (running),
    .select  (prescale_select),
    .tick    (tick)
  );

  // Match counted once per tick, so a held count is not counted twice
  logic match_event;
  assign match_event = match && tick;

  pmt_postscaler #(.WIDTH(4)) u_postscaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (scaler_clear),
    .match   (match_event),
    .select  (postscale_select),
    .done    (post_done)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control <= `PMT_CONTROL_RST;
    end else if (wr_control) begin
      timer_control <= wr_data[7:0] & `PMT_CONTROL_WMASK;
    end
  end

  // Control write does not touch the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count <= `PMT_COUNT_RST;
    end else if (wr_count) begin
      timer_count <= wr_data[7:0];
    end else if (tick) begin
      timer_count <= match ? 8'h00 : timer_count + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_period <= `PMT_PERIOD_RST;
    end else if (wr_period && !asleep) begin
      timer_period <= wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_irq_enable <= 1'b0;
      sleep_reg        <= 1'b0;
    end else begin
      if (wr_mask) match_irq_enable <= wr_data[0];
      if (wr_sleep) sleep_reg <= wr_data[0];
    end
  end

  // ==========================================================
  // Read channel
  logic rd_take;
  logic rd_status;
  logic [31:0] rd_value;
  logic rd_mapped;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign rd_status     = rd_take && addr_hit(s_axi_araddr, `PMT_OFF_STATUS);

  assign rd_mapped = addr_hit(s_axi_araddr, `PMT_OFF_CONTROL) || addr_hit(s_axi_araddr, `PMT_OFF_COUNT) ||
                     addr_hit(s_axi_araddr, `PMT_OFF_PERIOD) || addr_hit(s_axi_araddr, `PMT_OFF_STATUS) ||
                     addr_hit(s_axi_araddr, `PMT_OFF_MASK) || addr_hit(s_axi_araddr, `PMT_OFF_SLEEP);

  assign rd_value = addr_hit(s_axi_araddr, `PMT_OFF_CONTROL) ? {24'h0, timer_control} :
                    addr_hit(s_axi_araddr, `PMT_OFF_COUNT)   ? {24'h0, timer_count} :
                    addr_hit(s_axi_araddr, `PMT_OFF_PERIOD)  ? {24'h0, timer_period} :
                    addr_hit(s_axi_araddr, `PMT_OFF_STATUS)  ? {31'h0, match_flag} :
                    addr_hit(s_axi_araddr, `PMT_OFF_MASK)    ? {31'h0, match_irq_enable} :
                    addr_hit(s_axi_araddr, `PMT_OFF_SLEEP)   ? {31'h0, sleep_reg} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PMT_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_mapped ? `PMT_RESP_OKAY : `PMT_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Match flag: set wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_flag <= 1'b0;
    end else if (post_done) begin
      match_flag <= 1'b1;
    end else if (rd_status) begin
      match_flag <= 1'b0;
    end
  end

  assign irq = match_flag && match_irq_enable;
endmodule

// ### bench/pmt_timer_props.sv
module pmt_timer_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_sleep,
  input wire logic        pwm_time_base,
  input wire logic        spi_shift_clock,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Bus and timer checks
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs busy after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while pending");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while pending");
  a_spi_is_match: assert property (spi_shift_clock == pwm_time_base)
    else $error("shift clock differs from match");
  a_sleep_frozen: assert property ($past(cpu_sleep) |-> $stable(pwm_time_base))
    else $error("match moved during sleep");
  // Only a status read or a mask write may lower a raised interrupt
  a_irq_sticky: assert property (irq && !s_axi_arvalid && !s_axi_awvalid && !s_axi_wvalid |=> irq)
    else $error("interrupt dropped without software action");
  cover property ($rose(irq));
  cover property (pwm_time_base && cpu_sleep);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind pmt_timer pmt_timer_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .cpu_sleep, .pwm_time_base, .spi_shift_clock, .irq);

// ### bench/pmt_timer_tb.sv
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module pmt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_rvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rready, cpu_sleep, pwm_time_base;
  logic        spi_shift_clock, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  int          fails = 0, compares = 0, cyc = 0, t0, t1;
  int          ps[3] = '{0, 3, 15};

  pmt_timer dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cpu_sleep(cpu_sleep), .pwm_time_base(pwm_time_base), .spi_shift_clock(spi_shift_clock), .irq(irq)
  );
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // ==========================================================
  // Bus tasks: all drives land 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge aclk);
      #1;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r = 2'b00);
    logic [1:0] p;
    p = 2'b11;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (p != 2'b00) begin
      // Ready seen now is what the next edge samples
      if (s_axi_awready === 1'b1) p[1] = 1'b0;
      if (s_axi_wready === 1'b1) p[0] = 1'b0;
      tick(1);
      if (!p[1]) s_axi_awvalid <= 1'b0;
      if (!p[0]) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) tick(1);
    `CHK("write response", r, s_axi_bresp)
    tick(1);
    s_axi_bready <= 1'b0;
    // Let an edge pass so the next call never reassigns in this step
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic hs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      hs = s_axi_arready;
      tick(1);
    end while (hs !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) tick(1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    tick(1);
    s_axi_rready <= 1'b0;
    tick(1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
    rd(a, d, rr);
    `CHK($sformatf("read %h", a), {r, e}, {rr, d})
  endtask

  // Waits for a rising level on the match or the interrupt output
  task automatic rise(input bit on_irq, output int t);
    logic was, cur;
    was = 1'b1;
    // A level already high must fall before a rise counts
    cur = on_irq ? irq : pwm_time_base;
    while (!(was === 1'b0 && cur === 1'b1)) begin
      was = cur;
      tick(1);
      cur = on_irq ? irq : pwm_time_base;
    end
    t = cyc;
  endtask

  // ==========================================================
  // Scenarios
  task t_regs;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'hff);
    rdc(8'h0c, 32'h0);
    wr(8'h00, 8'hfb);
    rdc(8'h00, 32'h7b);
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h33);
    wr(8'h08, 8'h5a);
    wr(8'h00, 8'h78);
    rdc(8'h04, 32'h33);
    rdc(8'h08, 32'h5a);
    wr(8'h18, 8'h01, 2'b10);
    rdc(8'h18, 32'h0, 2'b10);
  endtask

  task t_period;
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h03);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, {6'b000001, p[1:0]});
      rise(1'b0, t0);
      rise(1'b0, t1);
      `CHK("shift clock", 1'b1, spi_shift_clock)
      `CHK("match spacing", 16 << (2 * p), t1 - t0)
    end
  endtask

  task t_restart;
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h10);
    wr(8'h08, 8'h11);
    wr(8'h00, 8'h07);
    for (int i = 0; i < 2; i++) begin
      // Scalers about 200 of 256 cycles in; the write must restart the full 64 x 4 wait
      tick(200);
      wr(i ? 8'h04 : 8'h00, i ? 8'h10 : 8'h07);
      t0 = cyc;
      rise(1'b0, t1);
      `CHK("restart gap", 1'b1, (t1 - t0) inside {[240:262]})
    end
  endtask

  task t_sleep;
    logic [31:0] held;
    cpu_sleep <= 1'b1;
    tick(2);
    rd(8'h04, held, rr);
    wr(8'h08, 8'h22);
    tick(600);
    rdc(8'h04, held);
    rdc(8'h08, 32'h11);
    cpu_sleep <= 1'b0;
    wr(8'h14, 8'h01);
    rd(8'h04, held, rr);
    tick(300);
    rdc(8'h04, held);
    rdc(8'h14, 32'h1);
    wr(8'h14, 8'h00);
  endtask

  task t_reset;
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h33);
    wr(8'h08, 8'h5a);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    `CHK("irq after reset", 1'b0, irq)
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'hff);
  endtask

  task t_irq;
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h01);
    wr(8'h10, 8'h01);
    foreach (ps[i]) begin
      // Stop before clearing, so the flag cannot return before the wait
      wr(8'h00, {1'b0, ps[i][3:0], 3'b000});
      rd(8'h0c, d, rr);
      wr(8'h00, {1'b0, ps[i][3:0], 3'b100});
      rise(1'b1, t0);
      rdc(8'h0c, 32'h1);
      `CHK("irq after clear", 1'b0, irq)
      rise(1'b1, t1);
      `CHK("flag spacing", 8 * (ps[i] + 1), t1 - t0)
    end
    wr(8'h10, 8'h00);
    rd(8'h0c, d, rr);
    tick(200);
    `CHK("masked irq", 1'b0, irq)
    wr(8'h10, 8'h01);
    `CHK("unmasked irq", 1'b1, irq)
    rdc(8'h0c, 32'h1);
  endtask

  task close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge aclk);
    fails++;
    close_out;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cpu_sleep} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    tick(8);
    aresetn <= 1'b1;
    tick(1);
    t_regs;
    t_period;
    t_restart;
    t_sleep;
    t_irq;
    t_reset;
    close_out;
  end
endmodule
